/* hdl/sifm_pkg.sv */
`default_nettype none
package sifm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 32'h0000_000A;
  localparam int unsigned TICK_PERIOD_NS = 32'h0000_2710;
  localparam int unsigned TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_STEPS = 32'h0000_0014;

  // ----------------------------------------------------------------
  // Channel layout and frequency limits (tenths of a hertz)
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH = 32'h0000_0008;
  localparam int unsigned NUM_PAIR = 32'h0000_0004;
  localparam logic [15:0] MIN_FREQ_DHZ = 16'h0014;
  localparam logic [15:0] MAX_FREQ_DHZ = 16'h1388;
  localparam logic [15:0] FREQ_SAT = 16'hFFFF;
  // Ticks per second times ten: quotient by period ticks gives 0.1 Hz
  localparam logic [19:0] FREQ_NUMER = 20'hF4240;
  // Longest period still at or above the minimum frequency
  localparam logic [15:0] PER_MAX_TICKS = 16'hC350;

  // ----------------------------------------------------------------
  // Object dictionary entries
  // ----------------------------------------------------------------
  localparam logic [15:0] OD_IDX_FREQ = 16'hA008;
  localparam logic [15:0] OD_IDX_PEAK = 16'hA009;
  localparam logic [7:0] OD_SUB_COUNT = 8'h00;
  localparam logic [15:0] OD_COUNT_VAL = 16'h0008;
  localparam logic [15:0] PEAK_RESET = 16'h0000;
  localparam logic [15:0] FREQ_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PM_DIGITAL = 3'b000,
    PM_VEL_X = 3'b001,
    PM_VEL_Y = 3'b010,
    PM_VEL_XY = 3'b011,
    PM_SYNC = 3'b100,
    PM_ENC = 3'b101
  } sifm_mode_t;

  typedef enum logic [0:0] {
    DV_IDLE = 1'b0,
    DV_RUN = 1'b1
  } sifm_div_t;

  typedef struct packed {
    logic rd;
    logic [15:0] index;
    logic [7:0] sub;
  } sifm_od_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] data;
  } sifm_od_rsp_t;

  typedef struct packed {
    logic [7:0] in_prev;
    logic [9:0] tick_cnt;
    logic tick;
    logic [7:0][15:0] per_cnt;
    logic [7:0] armed;
    logic [7:0][15:0] per_lat;
    logic [7:0] pend;
    logic [7:0][15:0] freq;
    logic [7:0][15:0] peak;
    sifm_div_t dv;
    logic [2:0] dv_ch;
    logic [4:0] dv_step;
    logic [15:0] dv_div;
    logic [16:0] dv_rem;
    logic [19:0] dv_quo;
    logic [7:0] logic_out;
    logic diag;
    logic ack_prev;
    sifm_od_rsp_t od;
  } sifm_state_t;
endpackage
`default_nettype wire

/* hdl/sifm_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module sifm_monitor
  import sifm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Pulse inputs and safe results
  input wire logic [7:0] channel_i,
  output logic [7:0] safe_logic_o,
  // Safe parameters
  input wire logic [3:0][2:0] pair_logic_mode_i,
  input wire logic [7:0][15:0] limit_dhz_i,
  // Diagnostic
  input wire logic error_acknowledge_i,
  output logic over_range_diag_o,
  // Object dictionary read port
  input wire sifm_od_req_t od_req_i,
  output sifm_od_rsp_t od_rsp_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic below_limit(input logic [15:0] f, input logic [15:0] lim);
    below_limit = f < lim;
  endfunction

  function automatic sifm_od_rsp_t od_pick(input logic [7:0][15:0] tbl, input logic [7:0] sub);
    od_pick.valid = 1'b1;
    od_pick.err = 1'b0;
    od_pick.data = 16'h0000;
    if (sub == OD_SUB_COUNT) begin
      od_pick.data = OD_COUNT_VAL;
    end else if (sub <= 8'(NUM_CH)) begin
      od_pick.data = tbl[3'(sub - 8'h01)];
    end else begin
      od_pick.err = 1'b1;
    end
  endfunction

  sifm_state_t st_q;
  sifm_state_t st_d;
  logic [7:0] fall;
  logic dv_done;
  logic [15:0] dv_freq;
  logic ack_rise;
  logic over_now;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [16:0] rem_sh;
    logic [19:0] quo_n;
    logic [2:0] pick;
    logic found;
    logic bx;
    logic by;
    st_d = st_q;
    rem_sh = 17'h00000;
    quo_n = 20'h00000;
    pick = 3'h0;
    found = 1'b0;
    bx = 1'b0;
    by = 1'b0;
    dv_done = 1'b0;
    dv_freq = FREQ_RESET;
    over_now = 1'b0;
    fall = st_q.in_prev & ~channel_i;
    ack_rise = error_acknowledge_i & ~st_q.ack_prev;
    st_d.in_prev = channel_i;
    st_d.ack_prev = error_acknowledge_i;

    // Common 10 us time base for all period counters
    st_d.tick = 1'b0;
    if (st_q.tick_cnt == 10'(TICK_CYC - 1)) begin
      st_d.tick_cnt = 10'h000;
      st_d.tick = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 10'h001;
    end

    // Serial divider: one channel at a time, 20 steps each
    case (st_q.dv)
      DV_IDLE: begin
        for (int i = NUM_CH - 1; i >= 0; i--) begin
          if (st_q.pend[i]) begin
            pick = 3'(i);
            found = 1'b1;
          end
        end
        if (found) begin
          st_d.dv = DV_RUN;
          st_d.dv_ch = pick;
          st_d.dv_div = st_q.per_lat[pick];
          st_d.pend[pick] = 1'b0;
          st_d.dv_step = 5'h00;
          st_d.dv_rem = 17'h00000;
          st_d.dv_quo = 20'h00000;
        end
      end
      DV_RUN: begin
        rem_sh = {st_q.dv_rem[15:0], FREQ_NUMER[5'(DIV_STEPS - 1) - st_q.dv_step]};
        if (rem_sh >= {1'b0, st_q.dv_div}) begin
          st_d.dv_rem = rem_sh - {1'b0, st_q.dv_div};
          quo_n = {st_q.dv_quo[18:0], 1'b1};
        end else begin
          st_d.dv_rem = rem_sh;
          quo_n = {st_q.dv_quo[18:0], 1'b0};
        end
        st_d.dv_quo = quo_n;
        st_d.dv_step = st_q.dv_step + 5'h01;
        if (st_q.dv_step == 5'(DIV_STEPS - 1)) begin
          dv_done = 1'b1;
          st_d.dv = DV_IDLE;
          dv_freq = (quo_n > {4'h0, FREQ_SAT}) ? FREQ_SAT : quo_n[15:0];
          if (dv_freq < MIN_FREQ_DHZ) begin
            dv_freq = FREQ_RESET;
          end
          over_now = dv_freq > MAX_FREQ_DHZ;
          st_d.freq[st_q.dv_ch] = dv_freq;
          if (dv_freq > st_q.peak[st_q.dv_ch]) begin
            st_d.peak[st_q.dv_ch] = dv_freq;
          end
        end
      end
      default: begin
        st_d.dv = DV_IDLE;
      end
    endcase

    // Period between falling edges; silence past 0.5 s means below 2 Hz
    for (int i = 0; i < NUM_CH; i++) begin
      if (fall[i]) begin
        if (st_q.armed[i] && st_q.per_cnt[i] <= PER_MAX_TICKS) begin
          st_d.per_lat[i] = st_q.per_cnt[i];
          st_d.pend[i] = 1'b1;
        end
        st_d.armed[i] = 1'b1;
        st_d.per_cnt[i] = 16'h0000;
      end else if (st_q.tick && st_q.armed[i]) begin
        // Exactly 2 Hz still measures; only a longer silence drops to zero
        if (st_q.per_cnt[i] >= PER_MAX_TICKS) begin
          st_d.armed[i] = 1'b0;
          st_d.pend[i] = 1'b0;
          st_d.freq[i] = FREQ_RESET;
        end else begin
          st_d.per_cnt[i] = st_q.per_cnt[i] + 16'h0001;
        end
      end
    end

    // Set wins over the acknowledge edge
    st_d.diag = over_now | (st_q.diag & ~ack_rise);

    // Safe result per pair; undefined modes fall to the safe 0
    for (int p = 0; p < NUM_PAIR; p++) begin
      bx = below_limit(st_q.freq[2 * p], limit_dhz_i[2 * p]);
      by = below_limit(st_q.freq[2 * p + 1], limit_dhz_i[2 * p + 1]);
      case (pair_logic_mode_i[p])
        PM_DIGITAL: begin
          st_d.logic_out[2 * p] = channel_i[2 * p];
          st_d.logic_out[2 * p + 1] = channel_i[2 * p + 1];
        end
        PM_VEL_X: begin
          st_d.logic_out[2 * p] = bx;
          st_d.logic_out[2 * p + 1] = channel_i[2 * p + 1];
        end
        PM_VEL_Y: begin
          st_d.logic_out[2 * p] = channel_i[2 * p];
          st_d.logic_out[2 * p + 1] = by;
        end
        PM_VEL_XY: begin
          st_d.logic_out[2 * p] = bx;
          st_d.logic_out[2 * p + 1] = by;
        end
        // Encoder states are never judged, only frequencies
        PM_SYNC, PM_ENC: begin
          st_d.logic_out[2 * p] = bx & by;
          st_d.logic_out[2 * p + 1] = bx & by;
        end
        default: begin
          st_d.logic_out[2 * p] = 1'b0;
          st_d.logic_out[2 * p + 1] = 1'b0;
        end
      endcase
    end

    // Object dictionary read, answered one cycle later
    st_d.od = '0;
    if (od_req_i.rd) begin
      if (od_req_i.index == OD_IDX_FREQ) begin
        st_d.od = od_pick(st_q.freq, od_req_i.sub);
      end else if (od_req_i.index == OD_IDX_PEAK) begin
        st_d.od = od_pick(st_q.peak, od_req_i.sub);
      end else begin
        st_d.od.valid = 1'b1;
        st_d.od.err = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign safe_logic_o = st_q.logic_out;
  assign over_range_diag_o = st_q.diag;
  assign od_rsp_o = st_q.od;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  logic min_bad;
  always_comb begin
    min_bad = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (st_q.freq[i] != FREQ_RESET && st_q.freq[i] < MIN_FREQ_DHZ) begin
        min_bad = 1'b1;
      end
    end
  end

  sequence s_fall0;
    st_q.in_prev[0] && !channel_i[0] && st_q.armed[0] && (st_q.per_cnt[0] <= PER_MAX_TICKS);
  endsequence

  sequence s_div_ch0;
    st_q.dv == DV_RUN && st_q.dv_ch == 3'h0;
  endsequence

  AST_FALL_MEASURES: assert property (s_fall0 |-> ##[1:250] s_div_ch0)
    else $error("falling edge on channel 0 never reached the divider");
  AST_MIN_ZERO: assert property (!min_bad)
    else $error("frequency under minimum not shown as zero");
  AST_OVER_SETS: assert property (dv_done && over_now |=> over_range_diag_o)
    else $error("over-range frequency did not raise diagnostic");
  AST_DIAG_HOLDS: assert property (over_range_diag_o && !ack_rise |=> over_range_diag_o)
    else $error("diagnostic dropped without acknowledge edge");
  AST_DIAG_CLEARS: assert property (ack_rise && !over_now |=> !over_range_diag_o)
    else $error("acknowledge edge did not clear diagnostic");
  AST_SINGLE: assert property (pair_logic_mode_i[0] == PM_VEL_X
      |=> safe_logic_o[0] == ($past(st_q.freq[0]) < $past(limit_dhz_i[0])))
    else $error("single channel result disagrees with limit");
  AST_PAIR: assert property ((pair_logic_mode_i[0] == PM_SYNC || pair_logic_mode_i[0] == PM_ENC)
      && (st_q.freq[0] >= limit_dhz_i[0] || st_q.freq[1] >= limit_dhz_i[1])
      |=> safe_logic_o[1:0] == 2'b00)
    else $error("pair result high while a limit reached");
  AST_EQUAL: assert property (pair_logic_mode_i[1] == PM_VEL_XY && st_q.freq[2] == limit_dhz_i[2]
      |=> !safe_logic_o[2])
    else $error("frequency equal to limit reported as below");
  AST_OD_READ: assert property (od_req_i.rd && od_req_i.index == OD_IDX_FREQ && od_req_i.sub == 8'h01
      |=> od_rsp_o.valid && !od_rsp_o.err && od_rsp_o.data == $past(st_q.freq[0]))
    else $error("channel 1 frequency read returned wrong data");

endmodule // sifm_monitor
`default_nettype wire

/* testbench/sifm_pulse_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sifm_pulse_model (
  // Clock and run control
  input wire logic sys_clk_i,
  input wire logic run_i,
  // Sensor lines, one per channel
  output logic [7:0] channel_o
);
  // ----------------------------------------------------------------
  // Periods in cycles, one pair per input pair
  // ----------------------------------------------------------------
  localparam int P[8] = '{10000, 16000, 20000, 25000, 32000, 32000, 40000, 40000};
  int t = 0;

  // First falling edge at cycle 100, except channels 5 and 7, so two edges fit in the run
  function automatic int off(input int i);
    int o;
    o = P[i] / 2 - 100;
    if (i == 5) o = o + P[i] / 4;
    if (i == 7) o = o + P[i] / 2;
    return o % P[i];
  endfunction

  // Lines freeze while stopped
  always_ff @(negedge sys_clk_i) begin
    if (run_i) t <= t + 1;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // Plain pulses only, no test gaps on velocity inputs
      channel_o[i] = ((t + off(i)) % P[i]) < P[i] / 2;
    end
  end
endmodule // sifm_pulse_model
`default_nettype wire

/* testbench/sifm_monitor_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module sifm_monitor_tb_top;
  import sifm_pkg::*;
  // ----------------------------------------------------------------
  // Tables
  // ----------------------------------------------------------------
  localparam int TK[8] = '{10, 16, 20, 25, 32, 32, 40, 40};
  // Pair modes p3..p0, then channels whose limit is the frequency plus one, which wraps to 0 on channel 0
  localparam logic [19:0] ROWS[8] = '{20'h95BFF, 20'h95B00, 20'h94AFF, 20'h000FF,
                                      20'hF91FF, 20'h95B1A, 20'h95BC6, 20'h6ACFE};
  logic sys_clk_i;
  logic reset_i = 1'b1;
  wire logic [7:0] channel_i;
  logic [7:0] safe_logic_o;
  logic [3:0][2:0] mode = '0;
  logic [7:0][15:0] lim = '0;
  logic ack = 1'b1;
  logic diag;
  logic run = 1'b0;
  sifm_od_req_t req = '0;
  sifm_od_rsp_t rsp;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;

  sifm_monitor dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .channel_i(channel_i),
    .safe_logic_o(safe_logic_o), .pair_logic_mode_i(mode), .limit_dhz_i(lim),
    .error_acknowledge_i(ack), .over_range_diag_o(diag), .od_req_i(req), .od_rsp_o(rsp));
  sifm_pulse_model model_u (.sys_clk_i(sys_clk_i), .run_i(run), .channel_o(channel_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] freq(input int i);
    logic [19:0] q;
    q = FREQ_NUMER / TK[i];
    return (q > FREQ_SAT) ? FREQ_SAT : q[15:0];
  endfunction

  // Zero frequency stands in for every channel after a reset
  function automatic logic [7:0] expect_out(input logic [3:0][2:0] m, input logic [7:0][15:0] l,
                                            input logic [7:0] lv, input logic zf);
    logic [7:0] e;
    logic bx;
    logic by;
    e = '0;
    for (int p = 0; p < 4; p++) begin
      bx = (zf ? 16'h0000 : freq(2 * p)) < l[2 * p];
      by = (zf ? 16'h0000 : freq(2 * p + 1)) < l[2 * p + 1];
      case (m[p])
        PM_DIGITAL: e[2 * p +: 2] = lv[2 * p +: 2];
        PM_VEL_X: e[2 * p +: 2] = {lv[2 * p + 1], bx};
        PM_VEL_Y: e[2 * p +: 2] = {by, lv[2 * p]};
        PM_VEL_XY: e[2 * p +: 2] = {by, bx};
        PM_SYNC, PM_ENC: e[2 * p +: 2] = {2{bx & by}};
        default: e[2 * p +: 2] = 2'h0;
      endcase
    end
    return e;
  endfunction

  task automatic od_read(input logic [15:0] idx, input logic [7:0] sub, input logic [17:0] exp);
    req = '{1'b1, idx, sub};
    @(negedge sys_clk_i);
    // Answer stands only in the cycle after the strobe edge
    chk("od_rsp", rsp, exp);
    req.rd = 1'b0;
    @(negedge sys_clk_i);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_i = 1'b0;
    chk("safe_logic", safe_logic_o, 32'h0);
    chk("diag", diag, 32'h0);
    chk("od_rsp", rsp, 32'h0);
    @(negedge sys_clk_i);
    od_read(OD_IDX_FREQ, 8'h01, {2'b10, FREQ_RESET});
    $display("Test reset done");
    run <= 1'b1;
    repeat (500) @(negedge sys_clk_i);
    od_read(OD_IDX_FREQ, 8'h01, 18'h20000);
    repeat (62000) @(negedge sys_clk_i);
    run <= 1'b0;
    repeat (300) @(negedge sys_clk_i);
    chk("diag", diag, 32'h1);
    for (int i = 0; i < 8; i++) begin
      od_read(OD_IDX_FREQ, 8'(i + 1), {2'b10, freq(i)});
      od_read(OD_IDX_PEAK, 8'(i + 1), {2'b10, freq(i)});
    end
    od_read(OD_IDX_FREQ, OD_SUB_COUNT, {2'b10, OD_COUNT_VAL});
    od_read(OD_IDX_FREQ, 8'h09, 18'h30000);
    od_read(16'h1234, 8'h01, 18'h30000);
    $display("Test readout done");
    for (int r = 0; r < 8; r++) begin
      mode = ROWS[r][19:8];
      for (int i = 0; i < 8; i++) lim[i] = freq(i) + {15'h0, ROWS[r][i]};
      repeat (2) @(negedge sys_clk_i);
      chk("safe_logic", safe_logic_o,
          expect_out(mode, lim, channel_i, 1'b0));
    end
    $display("Test modes done");
    ack = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk("diag", diag, 32'h1);
    ack = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk("diag", diag, 32'h0);
    $display("Test acknowledge done");
    reset_i = 1'b1;
    @(negedge sys_clk_i);
    reset_i = 1'b0;
    chk("safe_logic", safe_logic_o, 32'h0);
    @(negedge sys_clk_i);
    od_read(OD_IDX_PEAK, 8'h01, {2'b10, PEAK_RESET});
    chk("safe_logic", safe_logic_o, expect_out(mode, lim, channel_i, 1'b1));
    $display("Test second reset done");
    end_sim();
  end
endmodule // sifm_monitor_tb_top
`default_nettype wire
